//--- sebl_loader.v
`timescale 1ns/100ps
`include "sebl_map.vh"
module sebl_loader #(
  parameter [15:0] HALF_CYC = `SEBL_HALF_CYC
) (
  // clock and reset
  input wire clock_i,
  input wire srst_i,
  // serial clock, open drain
  input wire scl_i,
  output wire scl_o,
  output wire scl_oe_o,
  // serial data, open drain
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  // sdram word writes
  output wire wr_valid_o,
  input wire wr_ready_i,
  output wire [31:0] wr_addr_o,
  output wire [31:0] wr_data_o,
  // loaded configuration and status
  output reg [31:0] cacheable_region_limit_o,
  output reg [31:0] sdram_window_base_o,
  output reg busy_o,
  output reg done_o,
  output reg error_o
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_STA_A = 4'h1;
  localparam [3:0] ST_STA_B = 4'h2;
  localparam [3:0] ST_STA_C = 4'h3;
  localparam [3:0] ST_LOW = 4'h4;
  localparam [3:0] ST_HIGH = 4'h5;
  localparam [3:0] ST_WAITBUF = 4'h6;
  localparam [3:0] ST_STO_A = 4'h7;
  localparam [3:0] ST_STO_B = 4'h8;
  localparam [3:0] ST_STO_C = 4'h9;
  localparam [3:0] ST_STO_D = 4'ha;
  localparam [3:0] ST_DONE = 4'hb;
  localparam [15:0] HALF = HALF_CYC;

  reg [3:0] state;
  reg [15:0] timer;
  reg [1:0] step;
  reg rd;
  reg [3:0] bitcnt;
  reg [7:0] tx;
  reg [7:0] rx;
  reg [11:0] line;
  reg [10:0] count;
  reg [31:0] word;
  reg [1:0] lane;
  reg [8:0] widx;
  reg [31:0] pend_addr;
  reg [31:0] pend_data;
  reg pend_last;
  reg scl_s1, scl_s2, scl_s3, scl_q;
  reg sda_s1, sda_s2, sda_s3, sda_q;
  reg bit_low;
  wire timer_zero;
  wire last_now;
  wire buf_ready;
  wire [31:0] next_word;

  assign timer_zero = (timer == 16'h0000);
  assign next_word = {word[23:0], rx};
  // final line is the count plus the index of the last header line before the program
  assign last_now = rd &
    (line == ({1'b0, count} + `SEBL_LINE_BASE_LAST));

  // pins: only ever pull low, release otherwise
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = (state == ST_STA_A) | (state == ST_LOW) |
    (state == ST_WAITBUF) | (state == ST_STO_A) | (state == ST_STO_B);
  assign sda_oe_o = bit_low | (state == ST_STA_C) |
    (state == ST_STO_B) | (state == ST_STO_C);

  // data line level for the current bit slot
  always @* begin
    bit_low = 1'b0;
    if ((state == ST_LOW) | (state == ST_HIGH)) begin
      if (bitcnt < 4'h8) begin
        bit_low = ~rd & ~tx[7];
      end else begin
        bit_low = rd & ~last_now;
      end
    end
  end

  // three-stage samplers; a change counts when stages two and three agree
  always @(posedge clock_i) begin
    if (srst_i) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      scl_q <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      if (scl_s2 == scl_s3) begin
        scl_q <= scl_s3;
      end
      if (sda_s2 == sda_s3) begin
        sda_q <= sda_s3;
      end
    end
  end

  // word buffer toward the sdram writer
  sebl_buf2 #(
    .WIDTH(64)
  ) u_buf (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .in_valid_i(state == ST_WAITBUF),
    .in_ready_o(buf_ready),
    .in_data_i({pend_addr, pend_data}),
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i),
    .out_data_o({wr_addr_o, wr_data_o})
  );

  // link sequencer and byte unpacker
  always @(posedge clock_i) begin
    if (srst_i) begin
      state <= ST_IDLE;
      timer <= 16'h0000;
      step <= 2'h0;
      rd <= 1'b0;
      bitcnt <= 4'h0;
      tx <= 8'h00;
      rx <= 8'h00;
      line <= 12'h000;
      count <= 11'h000;
      word <= `SEBL_RST_WORD;
      lane <= 2'h0;
      widx <= 9'h000;
      pend_addr <= `SEBL_RST_WORD;
      pend_data <= `SEBL_RST_WORD;
      pend_last <= 1'b0;
      cacheable_region_limit_o <= `SEBL_RST_WORD;
      sdram_window_base_o <= `SEBL_RST_WORD;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      error_o <= 1'b0;
    end else begin
      if (~timer_zero) begin
        timer <= timer - 16'h0001;
      end
      case (state)
        // start the whole load straight after reset
        ST_IDLE: begin
          busy_o <= 1'b1;
          timer <= HALF;
          state <= ST_STA_A;
        end
        ST_STA_A: begin
          if (timer_zero) begin
            timer <= HALF;
            state <= ST_STA_B;
          end
        end
        // a target holding the clock low stretches the high phase
        ST_STA_B: begin
          if (~scl_q) begin
            timer <= HALF;
          end else if (timer_zero) begin
            timer <= HALF;
            state <= ST_STA_C;
          end
        end
        // start condition done, send the address byte
        ST_STA_C: begin
          if (timer_zero) begin
            if (step == 2'h0) begin
              tx <= {`SEBL_DEV_ADDR, `SEBL_DIR_WRITE};
            end else begin
              tx <= {`SEBL_DEV_ADDR, `SEBL_DIR_READ};
            end
            rd <= 1'b0;
            bitcnt <= 4'h0;
            timer <= HALF;
            state <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (timer_zero) begin
            timer <= HALF;
            state <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (~scl_q) begin
            timer <= HALF;
          end else if (timer_zero) begin
            timer <= HALF;
            if (bitcnt < 4'h8) begin
              rx <= {rx[6:0], sda_q};
              tx <= {tx[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
              state <= ST_LOW;
            end else if (~rd) begin
              bitcnt <= 4'h0;
              if (sda_q) begin
                // target refused a byte: give up cleanly
                error_o <= 1'b1;
                state <= ST_STO_A;
              end else if (step == 2'h0) begin
                step <= 2'h1;
                tx <= `SEBL_WORD_ADDR;
                state <= ST_LOW;
              end else if (step == 2'h1) begin
                step <= 2'h2;
                state <= ST_STA_A;
              end else begin
                step <= 2'h3;
                rd <= 1'b1;
                state <= ST_LOW;
              end
            end else begin
              bitcnt <= 4'h0;
              line <= line + 12'h001;
              pend_last <= last_now;
              state <= last_now ? ST_STO_A : ST_LOW;
              if (line == `SEBL_LINE_CNT_HI) begin
                count[10:8] <= rx[2:0];
              end
              if (line == `SEBL_LINE_CNT_LO) begin
                count[7:0] <= rx;
              end
              if ((line >= `SEBL_LINE_LIM_FIRST) &
                  (line <= `SEBL_LINE_LIM_LAST)) begin
                cacheable_region_limit_o <=
                  {cacheable_region_limit_o[23:0], rx};
              end
              if ((line >= `SEBL_LINE_BASE_FIRST) &
                  (line <= `SEBL_LINE_BASE_LAST)) begin
                sdram_window_base_o <=
                  {sdram_window_base_o[23:0], rx};
              end
              if (line >= `SEBL_LINE_PROG_FIRST) begin
                // first byte lands in bits 31:24, i.e. base plus 3
                word <= next_word;
                lane <= lane + 2'h1;
                if (lane == 2'h3) begin
                  pend_data <= next_word;
                  pend_addr <= sdram_window_base_o +
                    {21'h000000, widx, 2'h0};
                  widx <= widx + 9'h001;
                  state <= ST_WAITBUF;
                end
              end
            end
          end
        end
        // clock held low while the buffer is full; nothing is lost
        ST_WAITBUF: begin
          timer <= HALF;
          if (buf_ready) begin
            state <= pend_last ? ST_STO_A : ST_LOW;
          end
        end
        // stop: clock low, then data low, clock up, data up
        ST_STO_A: begin
          if (timer_zero) begin
            timer <= HALF;
            state <= ST_STO_B;
          end
        end
        ST_STO_B: begin
          if (timer_zero) begin
            timer <= HALF;
            state <= ST_STO_C;
          end
        end
        ST_STO_C: begin
          if (~scl_q) begin
            timer <= HALF;
          end else if (timer_zero) begin
            timer <= HALF;
            state <= ST_STO_D;
          end
        end
        ST_STO_D: begin
          if (timer_zero) begin
            busy_o <= 1'b0;
            done_o <= ~error_o;
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_DONE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // sebl_loader

//--- sebl_map.vh
`ifndef SEBL_MAP_VH
`define SEBL_MAP_VH

// system clock rate and serial link half period
`define SEBL_CLK_MHZ 40
`define SEBL_HALF_NS 5000
`define SEBL_HALF_CYC ((`SEBL_HALF_NS * `SEBL_CLK_MHZ + 999) / 1000)

// eeprom addressing
`define SEBL_DEV_ADDR 7'h50
`define SEBL_WORD_ADDR 8'h00
`define SEBL_DIR_WRITE 1'b0
`define SEBL_DIR_READ 1'b1

// eeprom line layout
`define SEBL_LINE_CNT_HI 12'h009
`define SEBL_LINE_CNT_LO 12'h00a
`define SEBL_LINE_LIM_FIRST 12'h027
`define SEBL_LINE_LIM_LAST 12'h02a
`define SEBL_LINE_BASE_FIRST 12'h02b
`define SEBL_LINE_BASE_LAST 12'h02e
`define SEBL_LINE_PROG_FIRST 12'h02f

// reset values
`define SEBL_RST_WORD 32'h0000_0000

`endif

//--- sebl_buf2.v
`timescale 1ns/100ps
// two-entry buffer so a stalled sdram writer never drops a word
module sebl_buf2 #(
  parameter WIDTH = 64
) (
  // clock and reset
  input wire clock_i,
  input wire srst_i,
  // filling side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // draining side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem [0:1];
  reg wptr;
  reg rptr;
  reg [1:0] count;
  wire push;
  wire pop;

  // honest full and empty from the occupancy count
  assign in_ready_o = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign out_data_o = mem[rptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // storage, no reset needed on data
  always @(posedge clock_i) begin
    if (push) begin
      mem[wptr] <= in_data_i;
    end
  end

  // pointers and count
  always @(posedge clock_i) begin
    if (srst_i) begin
      wptr <= 1'b0;
      rptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wptr <= ~wptr;
      end
      if (pop) begin
        rptr <= ~rptr;
      end
      if (push & ~pop) begin
        count <= count + 2'h1;
      end else if (pop & ~push) begin
        count <= count - 2'h1;
      end
    end
  end

endmodule // sebl_buf2

//--- sebl_checker.sv
`timescale 1ns/100ps
`include "sebl_map.vh"
// port watcher for the loader; single clock domain
module sebl_checker #(
  parameter integer HALF = `SEBL_HALF_CYC
) (
  // clock and reset
  input wire clock_i,
  input wire srst_i,
  // line enables
  input wire scl_oe_o,
  input wire sda_oe_o,
  // word writes
  input wire wr_valid_o,
  input wire wr_ready_i,
  input wire [31:0] wr_addr_o,
  input wire [31:0] wr_data_o,
  // configuration and status
  input wire [31:0] cacheable_region_limit_o,
  input wire [31:0] sdram_window_base_o,
  input wire busy_o,
  input wire done_o
);
  // shortest legal low phase follows the loader's half period
  localparam [7:0] LOW_MIN = HALF - 1;
  reg [7:0] ph_cnt;
  reg scl_q;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (srst_i);
  // cycles since the clock enable last moved, saturating
  always @(posedge clock_i) begin
    scl_q <= scl_oe_o;
    if (srst_i || scl_oe_o != scl_q)
      ph_cnt <= 8'h00;
    else if (ph_cnt != 8'hff)
      ph_cnt <= ph_cnt + 8'h01;
  end
  AST_BUSY_START: assert property ($fell(srst_i) |=> busy_o)
    else $error("busy missing after reset release");
  AST_SCL_LOW: assert property ($fell(scl_oe_o) && busy_o |-> ph_cnt >= LOW_MIN)
    else $error("clock low phase too short");
  AST_START_HOLD: assert property ($rose(sda_oe_o) && !scl_oe_o |=> !scl_oe_o [*8])
    else $error("clock pulled too soon after start");
  AST_WR_HOLD: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_addr_o) && $stable(wr_data_o))
    else $error("word changed while stalled");
  AST_WR_ALIGN: assert property (wr_valid_o |-> wr_addr_o[1:0] == sdram_window_base_o[1:0])
    else $error("word address off the base grid");
  AST_CFG_HOLD: assert property (wr_valid_o |-> $stable(cacheable_region_limit_o) && $stable(sdram_window_base_o))
    else $error("configuration moved during writes");
  AST_DONE_IDLE: assert property (done_o |-> !busy_o && !scl_oe_o && !sda_oe_o)
    else $error("lines held after done");
  AST_DONE_STICKY: assert property (done_o |=> done_o)
    else $error("done dropped");
  COV_TAKE: cover property (wr_valid_o && wr_ready_i);
  COV_STALL: cover property (wr_valid_o && !wr_ready_i);
  COV_DONE: cover property ($rose(done_o));
endmodule // sebl_checker

bind sebl_loader sebl_checker #(.HALF(HALF_CYC)) sebl_checker_inst (
  .clock_i(clock_i),
  .srst_i(srst_i), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o),
  .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_addr_o(wr_addr_o),
  .wr_data_o(wr_data_o), .busy_o(busy_o), .done_o(done_o),
  .cacheable_region_limit_o(cacheable_region_limit_o),
  .sdram_window_base_o(sdram_window_base_o));

//--- sebl_eeprom.sv
`timescale 1ns/100ps
// eeprom stand-in on the wires; only ever pulls data low
module sebl_eeprom (
  // serial wires
  input wire scl_i,
  input wire sda_i,
  output reg sda_pull_o
);
  localparam [63:0] CFG = 64'h1234_5678_0010_0000;
  reg [7:0] sh, dat, ptr;
  reg rd, ackd;
  integer bitn = 0, nbyte = 0, nread = 0;
  reg [7:0] got [0:2];
  // count 12 at line 10, limit and base, program byte j is 47+j
  function [7:0] mem(input [7:0] a);
    if (a >= 8'h2f)
      mem = a;
    else if (a >= 8'h27)
      mem = CFG[(8'h2e - a) * 8 +: 8];
    else
      mem = (a == 8'h0a) ? 8'h0c : 8'h80;
  endfunction
  // start or stop; delay dodges data moving as the clock falls
  always @(sda_i) begin
    #1;
    if (scl_i) begin
      bitn = 0;
      rd = 1'b0;
      sda_pull_o = 1'b0;
    end
  end
  // sample on rising clock
  always @(posedge scl_i) begin
    if (bitn < 8)
      sh = {sh[6:0], sda_i};
    else if (rd)
      ackd = !sda_i;
    bitn = bitn + 1;
  end
  // drive on falling clock
  initial sda_pull_o = 1'b0;
  always @(negedge scl_i) begin
    if (bitn == 8 && !rd) begin
      if (nbyte < 3)
        got[nbyte] = sh;
      nbyte = nbyte + 1;
      sda_pull_o = (sh[7:1] == 7'h50) || (nbyte == 2);
      rd = sh[0] && (nbyte != 2);
      if (nbyte == 2)
        ptr = sh;
      ackd = 1'b1;
    end else if (bitn == 9) begin
      bitn = 0;
      sda_pull_o = 1'b0;
      if (rd && ackd) begin
        dat = mem(ptr);
        ptr = ptr + 8'h01;
        nread = nread + 1;
        sda_pull_o = !dat[7];
      end
    end else if (rd)
      sda_pull_o = (bitn < 8) && !dat[7 - bitn];
  end
endmodule // sebl_eeprom

//--- sebl_loader_bench.sv
`timescale 1ns/100ps
module sebl_loader_bench;
  localparam [63:0] ROWS [0:2] = '{64'h0010_0000_2f30_3132,
    64'h0010_0004_3334_3536, 64'h0010_0008_3738_393a};
  reg clock_i = 1'b0;
  reg srst_i = 1'b1;
  reg wr_ready_i = 1'b0;
  wire scl_oe_o, sda_oe_o, wr_valid_o, busy_o, done_o, error_o, pull;
  wire [31:0] wr_addr_o, wr_data_o, limit, base;
  // pull-ups: a released line reads high
  wire scl_w = ~scl_oe_o;
  wire sda_w = ~(sda_oe_o | pull);
  integer n_mismatch = 0, n_compared = 0, i, t;
  // short half period keeps the whole load well inside the run budget
  sebl_loader #(.HALF_CYC(16'd20)) sebl_loader_inst (.clock_i(clock_i),
    .srst_i(srst_i),
    .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe_o), .sda_i(sda_w),
    .sda_o(), .sda_oe_o(sda_oe_o), .wr_valid_o(wr_valid_o),
    .wr_ready_i(wr_ready_i), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
    .cacheable_region_limit_o(limit), .sdram_window_base_o(base),
    .busy_o(busy_o), .done_o(done_o), .error_o(error_o));
  sebl_eeprom sebl_eeprom_inst (.scl_i(scl_w), .sda_i(sda_w),
    .sda_pull_o(pull));
  // 40 MHz
  initial forever #12.5 clock_i = ~clock_i;
  task chk(input string name, input logic [31:0] exp, got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
    end
  endtask
  task end_of_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // bounded wait on a flag; running out ends the run
  task wait_hi(input integer which, input integer lim);
    t = 0;
    while ((which ? done_o : wr_valid_o) !== 1'b1 && t < lim) begin
      @(negedge clock_i);
      t = t + 1;
    end
    if (t >= lim) begin
      n_mismatch = n_mismatch + 1;
      end_of_test;
    end
  endtask
  initial begin
    repeat (6) @(posedge clock_i);
    #2;
    chk("reset", 32'h0, {scl_oe_o, sda_oe_o, wr_valid_o, busy_o, done_o});
    srst_i = 1'b0;
    @(posedge clock_i);
    #2;
    chk("busy", 32'h1, busy_o);
    $display("test reset done");
    // receiver stalls: buffer fills, loader must park the clock low
    wait_hi(0, 60000);
    repeat (6000) @(posedge clock_i);
    #2;
    chk("stall_scl", 32'h1, scl_oe_o);
    chk("stall_done", 32'h0, done_o);
    chk("stall_valid", 32'h1, wr_valid_o);
    wr_ready_i = 1'b1;
    $display("test stall done");
    // words drain back to back once space opens
    for (i = 0; i < 3; i = i + 1) begin
      @(negedge clock_i);
      wait_hi(0, 20000);
      chk("wr_addr", ROWS[i][63:32], wr_addr_o);
      chk("wr_data", ROWS[i][31:0], wr_data_o);
      @(posedge clock_i);
    end
    $display("test words done");
    wait_hi(1, 20000);
    chk("limit", 32'h1234_5678, limit);
    chk("base", 32'h0010_0000, base);
    chk("error", 32'h0, {error_o, wr_valid_o});
    chk("dev_write", 32'ha0, sebl_eeprom_inst.got[0]);
    chk("word_addr", 32'h00, sebl_eeprom_inst.got[1]);
    chk("dev_read", 32'ha1, sebl_eeprom_inst.got[2]);
    chk("lines_read", 32'd59, sebl_eeprom_inst.nread);
    chk("released", 32'h3, {scl_w, sda_w});
    $display("test finish done");
    end_of_test;
  end
endmodule // sebl_loader_bench
